//--- hdl/trace_accept_filter.sv
`timescale 1ns/1ps
module trace_accept_filter (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Received trace identifier.
   input wire logic id_valid,
   input wire logic [trib_alarm_pkg::TRACE_ID_W-1:0] id_in,
   // Settings.
   input wire logic trace_persistence_select,
   input wire logic unstable_algorithm_select,
   input wire logic [3:0] unstable_threshold,
   // Results.
   output logic trace_unstable_state,
   output logic [trib_alarm_pkg::TRACE_ID_W-1:0] accepted_id
);
   import trib_alarm_pkg::*;

   trace_state_t s;
   trace_state_t next_s;
   logic same;
   logic [2:0] need;

   // Persistence check and unstable counter for each received identifier.
   always_comb begin
      next_s = s;
      same = (id_in == s.last_id);
      need = trace_persistence_select ? TRACE_PERSIST_LONG
                                      : TRACE_PERSIST_SHORT;
      if (id_valid) begin
         next_s.last_id = id_in;
         if (!same) begin
            next_s.rep_cnt = 3'h1;
         end else if (s.rep_cnt != REP_CNT_MAX) begin
            next_s.rep_cnt = s.rep_cnt + 3'h1;
         end
         if (same && next_s.rep_cnt >= need) begin
            // Acceptance clears the count under either algorithm.
            next_s.accepted_id = id_in;
            next_s.unst_cnt = 5'h00;
            next_s.counting = 1'b0;
         end else if (unstable_algorithm_select) begin
            // Once started, every identifier counts until one is accepted.
            if (!same) begin
               next_s.counting = 1'b1;
            end
            if ((s.counting || !same) && s.unst_cnt != UNST_CNT_MAX) begin
               next_s.unst_cnt = s.unst_cnt + 5'h01;
            end
         end else if (!same && s.unst_cnt != UNST_CNT_MAX) begin
            next_s.unst_cnt = s.unst_cnt + 5'h01;
         end
      end
      next_s.unstable = next_s.unst_cnt > {1'b0, unstable_threshold};
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign trace_unstable_state = s.unstable;
   assign accepted_id = s.accepted_id;

   // Unstable is only ever declared above the threshold.
   a_unstable_above_thr: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(trace_unstable_state) |-> s.unst_cnt > {1'b0, $past(unstable_threshold)})
      else $error("Trace unstable declared at or below threshold.");

   // An accepted identifier clears the unstable count.
   a_accept_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
      $changed(accepted_id) |-> s.unst_cnt == 5'h00)
      else $error("Unstable count not cleared on acceptance.");

endmodule // trace_accept_filter

//--- hdl/trib_alarm_pkg.sv
package trib_alarm_pkg;

   // Bus and data widths.
   localparam int ADDR_W = 12;
   localparam int TRACE_ID_W = 8;

   // Register indexes; the byte address of each is four times its index.
   localparam logic [9:0] IDX_TRACE_CFG = 10'h00E;
   localparam logic [9:0] IDX_AIS_CTRL = 10'h010;
   localparam logic [9:0] IDX_RDI_CTRL = 10'h011;
   localparam logic [9:0] IDX_MODE = 10'h014;
   localparam logic [9:0] IDX_STATUS = 10'h015;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // Reset values and writable masks; unused bits read back as zero.
   localparam logic [7:0] RST_TRACE_CFG = 8'h06;
   localparam logic [7:0] RST_AIS_CTRL = 8'h00;
   localparam logic [7:0] RST_RDI_CTRL = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h80;
   localparam logic [7:0] MASK_TRACE_CFG = 8'hCF;
   localparam logic [7:0] MASK_AIS_CTRL = 8'hCF;
   localparam logic [7:0] MASK_RDI_CTRL = 8'hFF;
   localparam logic [7:0] MASK_MODE = 8'hF7;

   // Field positions of the overhead and trace configuration.
   localparam int CFG_PDI_MSB = 2;
   localparam int CFG_PDI_LSB = 0;
   localparam int CFG_RDI_DEPTH = 3;
   localparam int CFG_PERSIST = 6;
   localparam int CFG_ALGO = 7;

   // Cause positions, shared by the AIS and the RDI control registers.
   localparam int EN_TIU = 0;
   localparam int EN_TIM = 1;
   localparam int EN_LABEL_UNSTABLE_STATE = 2;
   localparam int EN_LABEL_MISMATCH_STATE = 3;
   localparam int EN_UNEQ = 4;
   localparam int EN_AIS = 5;
   localparam int EN_LOP = 6;
   localparam int EN_LOM = 7;

   // Mode register and status register fields.
   localparam int MODE_TU3 = 0;
   localparam int MODE_OH_RDI = 1;
   localparam int MODE_MASTER_LOP = 2;
   localparam int MODE_THR_LSB = 4;
   localparam int MODE_THR_MSB = 7;
   localparam int STAT_AIS = 0;
   localparam int STAT_RDI = 1;
   localparam int STAT_TIU = 2;
   localparam int STAT_PDI = 3;
   localparam int STAT_RDC_LSB = 4;
   localparam int STAT_RDC_MSB = 6;

   // Acceptance counts.
   localparam logic [2:0] TRACE_PERSIST_LONG = 3'h5;
   localparam logic [2:0] TRACE_PERSIST_SHORT = 3'h3;
   localparam logic [2:0] REP_CNT_MAX = 3'h7;
   localparam logic [4:0] UNST_CNT_MAX = 5'h1F;
   localparam logic [3:0] RDI_DEPTH_LONG = 4'hA;
   localparam logic [3:0] RDI_DEPTH_SHORT = 4'h5;
   localparam logic [3:0] RDI_CNT_MAX = 4'hF;
   localparam logic [7:0] AIS_FILL = 8'hFF;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic trace_mismatch_state;
      logic label_unstable_state;
      logic label_mismatch_state;
      logic unequipped;
      logic incoming_ais;
      logic pointer_loss;
      logic multiframe_loss;
   } alarm_state_t;

   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ANSWER = 2'b10
   } apb_state_t;

   typedef struct packed {
      apb_state_t apb_state;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] trace_cfg;
      logic [7:0] ais_ctrl;
      logic [7:0] rdi_ctrl;
      logic [7:0] mode;
      logic [2:0] rdi_last;
      logic [3:0] rdi_cnt;
      logic [2:0] rdi_accepted;
      logic pdi_detect;
      logic ais_active;
      logic rdi_alarm;
      logic rdi_v5;
      logic rdi_g1;
      logic [7:0] data_out;
      logic data_out_valid;
   } ctrl_state_t;

   typedef struct packed {
      logic [TRACE_ID_W-1:0] last_id;
      logic [TRACE_ID_W-1:0] accepted_id;
      logic [2:0] rep_cnt;
      logic [4:0] unst_cnt;
      logic counting;
      logic unstable;
   } trace_state_t;

endpackage

//--- hdl/tributary_alarm_action_control.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Hold a 3-bit defect code, reset 110, compared against V5 or C2 label.
// - For TU3 the compare byte sign-extends the code's top bit.
// - Remote defect code must persist ten times, or five with depth bit low.
// - Trace identifier accepted after five unchanged receptions, else three.
// - Alternate algorithm counts from first dissimilar identifier until accept.
// - Default algorithm counts each dissimilar identifier; cleared on accept.
// - Trace unstable and trace mismatch raise AIS when their enables are set.
// - Label unstable and label mismatch raise AIS when their enables are set.
// - Pointer loss raises AIS when local or master enable is set.
// - Multiframe loss raises AIS when enabled, never on TU3 streams.
// - Alarm AIS is removed only at a multiframe boundary.
// - RDI goes to the alarm port and optionally into V5, or G1 for TU3.
// - Trace unstable and trace mismatch report RDI when enabled.
// - Label unstable and label mismatch report RDI when enabled.
// - Unequipped reports RDI only while its enable is set.
// - Incoming AIS reports RDI only while its enable is set.
// - Pointer loss reports RDI only while its enable is set.
// - Multiframe loss reports RDI only while its enable is set.
// - Inserted AIS forces every byte of the tributary to all ones.
module tributary_alarm_action_control (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // APB register port.
   input wire trib_alarm_pkg::apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Alarm states from the detectors of this tributary.
   input wire trib_alarm_pkg::alarm_state_t alarm_in,
   // Received trace identifier.
   input wire logic trace_valid,
   input wire logic [trib_alarm_pkg::TRACE_ID_W-1:0] trace_id,
   // Received signal label (V5 label in bits 2:0, or the whole C2 byte).
   input wire logic label_valid,
   input wire logic [7:0] label_byte,
   // Received remote defect code.
   input wire logic rdi_valid,
   input wire logic [2:0] rdi_code,
   // Tributary stream.
   input wire logic multiframe_boundary,
   input wire logic data_in_valid,
   input wire logic [7:0] data_in,
   output logic data_out_valid,
   output logic [7:0] data_out,
   // Consequent actions.
   output logic ais_insert,
   output logic receive_alarm_port,
   output logic rdi_v5_insert,
   output logic rdi_g1_insert,
   output logic pdi_detect,
   output logic trace_unstable_state,
   output logic [2:0] remote_defect_code,
   output logic [trib_alarm_pkg::TRACE_ID_W-1:0] accepted_trace_id
);
   import trib_alarm_pkg::*;

   ctrl_state_t s;
   ctrl_state_t next_s;
   logic [9:0] idx;
   logic aligned;
   logic [7:0] rd_byte;
   logic hit;
   logic [7:0] pdi_byte;
   logic [3:0] rdi_depth;
   logic [7:0] cause;
   logic [7:0] ais_cause;
   logic [7:0] rdi_cause;
   logic ais_any;
   logic rdi_any;
   logic tu3;

   // The trace persistence and unstable counters live in their own block.
   trace_accept_filter trace_filter (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .id_valid(trace_valid),
      .id_in(trace_id),
      .trace_persistence_select(s.trace_cfg[CFG_PERSIST]),
      .unstable_algorithm_select(s.trace_cfg[CFG_ALGO]),
      .unstable_threshold(s.mode[MODE_THR_MSB:MODE_THR_LSB]),
      .trace_unstable_state(trace_unstable_state),
      .accepted_id(accepted_trace_id)
   );

   // Register decode; unmapped or misaligned words answer with an error.
   always_comb begin
      idx = apb_req.paddr[ADDR_W-1:2];
      aligned = (apb_req.paddr[1:0] == WORD_ALIGN);
      hit = aligned;
      case (idx)
         IDX_TRACE_CFG: rd_byte = s.trace_cfg;
         IDX_AIS_CTRL: rd_byte = s.ais_ctrl;
         IDX_RDI_CTRL: rd_byte = s.rdi_ctrl;
         IDX_MODE: rd_byte = s.mode;
         IDX_STATUS: rd_byte = {1'b0, s.rdi_accepted, s.pdi_detect,
                                trace_unstable_state, s.rdi_alarm,
                                s.ais_active};
         default: begin
            rd_byte = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   // Cause vector in the bit order of both control registers.
   always_comb begin
      tu3 = s.mode[MODE_TU3];
      cause = 8'h00;
      cause[EN_TIU] = trace_unstable_state;
      cause[EN_TIM] = alarm_in.trace_mismatch_state;
      cause[EN_LABEL_UNSTABLE_STATE] = alarm_in.label_unstable_state;
      cause[EN_LABEL_MISMATCH_STATE] = alarm_in.label_mismatch_state;
      cause[EN_UNEQ] = alarm_in.unequipped;
      cause[EN_AIS] = alarm_in.incoming_ais;
      cause[EN_LOP] = alarm_in.pointer_loss;
      cause[EN_LOM] = alarm_in.multiframe_loss;
      ais_cause = cause & s.ais_ctrl;
      // The local pointer-loss enable is OR-ed with the master copy.
      ais_cause[EN_LOP] = cause[EN_LOP] &
         (s.ais_ctrl[EN_LOP] | s.mode[MODE_MASTER_LOP]);
      // A TU3 stream carries no multiframe, so that cause is dropped.
      ais_cause[EN_LOM] = cause[EN_LOM] & s.ais_ctrl[EN_LOM] & ~tu3;
      rdi_cause = cause & s.rdi_ctrl;
      ais_any = |ais_cause;
      rdi_any = |rdi_cause;
   end

   // Comparison values for defect indication and remote defect filtering.
   always_comb begin
      if (tu3) begin
         pdi_byte = {{5{s.trace_cfg[CFG_PDI_MSB]}},
                     s.trace_cfg[CFG_PDI_MSB:CFG_PDI_LSB]};
      end else begin
         pdi_byte = {5'h00, s.trace_cfg[CFG_PDI_MSB:CFG_PDI_LSB]};
      end
      rdi_depth = s.trace_cfg[CFG_RDI_DEPTH] ? RDI_DEPTH_LONG
                                             : RDI_DEPTH_SHORT;
   end

   // Next state of the whole block.
   always_comb begin
      next_s = s;
      // APB answers one cycle into the access phase and commits on pready.
      case (s.apb_state)
         APB_IDLE: begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            if (apb_req.psel && apb_req.penable) begin
               next_s.apb_state = APB_ANSWER;
               next_s.pready = 1'b1;
               next_s.pslverr = ~hit;
               next_s.prdata = (hit && !apb_req.pwrite) ?
                               {24'h000000, rd_byte} : 32'h00000000;
            end
         end
         APB_ANSWER: begin
            next_s.apb_state = APB_IDLE;
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            if (apb_req.psel && apb_req.penable && apb_req.pwrite && hit) begin
               case (idx)
                  IDX_TRACE_CFG: next_s.trace_cfg =
                     apb_req.pwdata[7:0] & MASK_TRACE_CFG;
                  IDX_AIS_CTRL: next_s.ais_ctrl =
                     apb_req.pwdata[7:0] & MASK_AIS_CTRL;
                  IDX_RDI_CTRL: next_s.rdi_ctrl =
                     apb_req.pwdata[7:0] & MASK_RDI_CTRL;
                  IDX_MODE: next_s.mode = apb_req.pwdata[7:0] & MASK_MODE;
                  default: next_s.mode = s.mode;
               endcase
            end
         end
         default: begin
            next_s.apb_state = APB_IDLE;
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
         end
      endcase

      // Defect indication compare on each received label.
      if (label_valid) begin
         if (tu3) begin
            next_s.pdi_detect = (label_byte == pdi_byte);
         end else begin
            next_s.pdi_detect = (label_byte[2:0] == pdi_byte[2:0]);
         end
      end

      // Remote defect code filter: a new code restarts the persistence run.
      if (rdi_valid) begin
         next_s.rdi_last = rdi_code;
         if (rdi_code != s.rdi_last) begin
            next_s.rdi_cnt = 4'h1;
         end else if (s.rdi_cnt != RDI_CNT_MAX) begin
            next_s.rdi_cnt = s.rdi_cnt + 4'h1;
         end
         if (next_s.rdi_cnt >= rdi_depth) begin
            next_s.rdi_accepted = rdi_code;
         end
      end

      // AIS sets at once but is held until a multiframe boundary, so the
      // downstream equipment never sees AIS end partway through a multiframe.
      if (ais_any) begin
         next_s.ais_active = 1'b1;
      end else if (multiframe_boundary) begin
         next_s.ais_active = 1'b0;
      end

      // RDI to the alarm port, optionally into the overhead byte.
      next_s.rdi_alarm = rdi_any;
      next_s.rdi_v5 = rdi_any & s.mode[MODE_OH_RDI] & ~tu3;
      next_s.rdi_g1 = rdi_any & s.mode[MODE_OH_RDI] & tu3;

      // Stream output; AIS overwrites every byte rather than only overhead.
      next_s.data_out_valid = data_in_valid;
      if (data_in_valid) begin
         next_s.data_out = s.ais_active ? AIS_FILL : data_in;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.apb_state <= APB_IDLE;
         s.trace_cfg <= RST_TRACE_CFG;
         s.ais_ctrl <= RST_AIS_CTRL;
         s.rdi_ctrl <= RST_RDI_CTRL;
         s.mode <= RST_MODE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register.
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign data_out = s.data_out;
   assign data_out_valid = s.data_out_valid;
   assign ais_insert = s.ais_active;
   assign receive_alarm_port = s.rdi_alarm;
   assign rdi_v5_insert = s.rdi_v5;
   assign rdi_g1_insert = s.rdi_g1;
   assign pdi_detect = s.pdi_detect;
   assign remote_defect_code = s.rdi_accepted;

   // Checks on the consequent actions.
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   a_ais_release_edge: assert property (
      $fell(ais_insert) |-> $past(multiframe_boundary) && !$past(ais_any))
      else $error("AIS removed away from a multiframe boundary.");

   a_ais_cause_sets: assert property (
      ais_any |=> ais_insert)
      else $error("Enabled alarm did not raise AIS.");

   a_ais_disabled_quiet: assert property (
      (s.ais_ctrl == 8'h00 && !s.mode[MODE_MASTER_LOP] && !ais_insert)
      |=> !ais_insert)
      else $error("AIS raised with every enable low.");

   a_lop_master_or: assert property (
      (alarm_in.pointer_loss && s.mode[MODE_MASTER_LOP]) |=> ais_insert)
      else $error("Master pointer-loss enable did not raise AIS.");

   a_lom_tu3_ignored: assert property (
      (tu3 && (ais_cause == 8'h00) && !ais_insert
       && alarm_in.multiframe_loss) |=> !ais_insert)
      else $error("Multiframe loss raised AIS on a TU3 stream.");

   a_ais_all_ones: assert property (
      (ais_insert && data_in_valid) |=> data_out == AIS_FILL)
      else $error("AIS byte not all ones.");

   a_rdi_follows: assert property (
      rdi_any |=> receive_alarm_port ##0 (rdi_v5_insert == $past(
      s.mode[MODE_OH_RDI] && !tu3)))
      else $error("RDI not reported for an enabled cause.");

   a_rdi_masked: assert property (
      (s.rdi_ctrl == 8'h00) |=> !receive_alarm_port)
      else $error("RDI reported with every enable low.");

   a_rdi_depth_met: assert property (
      $changed(remote_defect_code) |->
      s.rdi_cnt >= (s.trace_cfg[CFG_RDI_DEPTH] ? RDI_DEPTH_LONG
                                               : RDI_DEPTH_SHORT))
      else $error("Remote defect code accepted too early.");

   a_pdi_tu3_match: assert property (
      (label_valid && tu3 && label_byte == pdi_byte) |=> pdi_detect)
      else $error("Sign-extended defect code not detected.");

   a_apb_answer: assert property (
      (apb_req.psel && apb_req.penable && !pready) |=> pready ##1 !pready)
      else $error("APB answer not one cycle long.");

   c_ais_release: cover property (
      ais_insert ##1 multiframe_boundary ##1 !ais_insert);
   c_rdi_g1: cover property (rdi_g1_insert);
   c_apb_write: cover property (
      pready && apb_req.pwrite && !pslverr);

endmodule // tributary_alarm_action_control

//--- tb/test_tributary_alarm_action_control.sv
`timescale 1ns/1ps
module test_tributary_alarm_action_control;
   import trib_alarm_pkg::*;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   apb_req_t apb_req = '0;
   alarm_state_t alarm_in = '0;
   logic trace_valid = 1'b0;
   logic [7:0] trace_id = 8'h00;
   logic label_valid = 1'b0;
   logic [7:0] label_byte = 8'h00;
   logic rdi_valid = 1'b0;
   logic [2:0] rdi_code = 3'h0;
   logic multiframe_boundary, data_in_valid, data_out_valid;
   logic [7:0] data_in, data_out, accepted_trace_id;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, ais_insert, receive_alarm_port;
   logic rdi_v5_insert, rdi_g1_insert, pdi_detect, trace_unstable_state;
   logic [2:0] remote_defect_code;
   int num_errors = 0;
   int comparisons = 0;

   trib_stream_source i_trib_stream_source (.clk_sys(clk_sys),
      .rstn(rstn), .multiframe_boundary(multiframe_boundary),
      .data_in_valid(data_in_valid), .data_in(data_in));

   tributary_alarm_action_control i_tributary_alarm_action_control (
      .clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .alarm_in(alarm_in),
      .trace_valid(trace_valid), .trace_id(trace_id),
      .label_valid(label_valid), .label_byte(label_byte),
      .rdi_valid(rdi_valid), .rdi_code(rdi_code),
      .multiframe_boundary(multiframe_boundary),
      .data_in_valid(data_in_valid), .data_in(data_in),
      .data_out_valid(data_out_valid), .data_out(data_out),
      .ais_insert(ais_insert), .receive_alarm_port(receive_alarm_port),
      .rdi_v5_insert(rdi_v5_insert), .rdi_g1_insert(rdi_g1_insert),
      .pdi_detect(pdi_detect), .trace_unstable_state(trace_unstable_state),
      .remote_defect_code(remote_defect_code),
      .accepted_trace_id(accepted_trace_id));

   // 125 MHz system clock.
   always #4 clk_sys = ~clk_sys;

   // Compares a result and counts the comparison.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
                  got, exp);
      end
   endtask

   // One APB transfer; waits for pready under a bound, result in rd/err.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      apb_req.psel <= 1'b1;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      chk(n < 20, 32'h1, "pready wait");
      rd = prdata;
      err = pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "register read");
   endtask

   // Sends one kind of strobe a number of times, each with a gap cycle.
   task automatic strobe(input int kind, input logic [7:0] v, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         trace_valid <= (kind == 0);
         label_valid <= (kind == 1);
         rdi_valid <= (kind == 2);
         trace_id <= v;
         label_byte <= v;
         rdi_code <= v[2:0];
         @(posedge clk_sys);
         trace_valid <= 1'b0;
         label_valid <= 1'b0;
         rdi_valid <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
   endtask

   // Returns just after the edge that consumed a boundary pulse.
   task automatic wait_boundary();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (multiframe_boundary !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   // Raises a cause, then checks that AIS holds until a boundary.
   task automatic ais_cycle(input alarm_state_t c);
      alarm_in <= c;
      repeat (3) @(posedge clk_sys);
      chk(ais_insert, 32'h1, "ais raised");
      chk(data_out, 32'hFF, "ais fill");
      wait_boundary();
      alarm_in <= '0;
      repeat (3) @(posedge clk_sys);
      chk(ais_insert, 32'h1, "ais held");
      wait_boundary();
      repeat (2) @(posedge clk_sys);
      chk(ais_insert, 32'h0, "ais removed");
      chk(data_out[7], 32'h0, "live data");
   endtask

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // A hang is cut short far beyond the expected run of some 600 cycles.
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_of_test();
   end

   // Main sequence.
   initial begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rdchk(12'h038, 32'h06);
      rdchk(12'h040, 32'h00);
      rdchk(12'h044, 32'h00);
      apb(1'b0, 12'h060, 32'h0);
      chk(err, 32'h1, "unmapped");
      apb(1'b1, 12'h039, 32'hFF);
      chk(err, 32'h1, "misaligned");
      apb(1'b1, 12'h038, 32'hFF);
      rdchk(12'h038, 32'hCF);
      apb(1'b1, 12'h040, 32'hFF);
      rdchk(12'h040, 32'hCF);
      apb(1'b1, 12'h044, 32'hFF);
      rdchk(12'h044, 32'hFF);
      apb(1'b1, 12'h038, 32'h06);
      $display("test registers done");
      for (int k = 1; k < 8; k++) begin
         apb(1'b1, 12'h044, {24'h0, ~(8'h01 << k)});
         alarm_in <= alarm_state_t'(7'h40 >> (k - 1));
         repeat (3) @(posedge clk_sys);
         chk(receive_alarm_port, 32'h0, "rdi masked");
         apb(1'b1, 12'h044, {24'h0, 8'h01 << k});
         // The enable lands at the completing edge; the report follows it.
         repeat (2) @(posedge clk_sys);
         chk(receive_alarm_port, 32'h1, "rdi on");
      end
      apb(1'b1, 12'h050, 32'h82);
      repeat (2) @(posedge clk_sys);
      chk(rdi_v5_insert, 32'h1, "v5 rdi");
      apb(1'b1, 12'h050, 32'h83);
      repeat (2) @(posedge clk_sys);
      chk(rdi_g1_insert, 32'h1, "g1 rdi");
      chk(rdi_v5_insert, 32'h0, "v5 rdi in tu3");
      alarm_in <= '0;
      apb(1'b1, 12'h050, 32'h80);
      $display("test rdi enables done");
      for (int k = 1; k < 8; k++) begin
         if (k == 4 || k == 5) continue;
         apb(1'b1, 12'h040, {24'h0, ~(8'h01 << k) & 8'hCF});
         alarm_in <= alarm_state_t'(7'h40 >> (k - 1));
         repeat (3) @(posedge clk_sys);
         chk(ais_insert, 32'h0, "ais masked");
         apb(1'b1, 12'h040, {24'h0, 8'h01 << k});
         ais_cycle(alarm_state_t'(7'h40 >> (k - 1)));
      end
      apb(1'b1, 12'h040, 32'h00);
      apb(1'b1, 12'h050, 32'h84);
      ais_cycle(alarm_state_t'(7'h02));
      apb(1'b1, 12'h040, 32'h80);
      apb(1'b1, 12'h050, 32'h81);
      alarm_in <= alarm_state_t'(7'h01);
      repeat (3) @(posedge clk_sys);
      chk(ais_insert, 32'h0, "lom in tu3");
      alarm_in <= '0;
      apb(1'b1, 12'h040, 32'h00);
      apb(1'b1, 12'h050, 32'h80);
      $display("test ais enables done");
      strobe(0, 8'h5A, 2);
      chk(accepted_trace_id, 32'h00, "trace early");
      strobe(0, 8'h5A, 1);
      chk(accepted_trace_id, 32'h5A, "trace three");
      apb(1'b1, 12'h038, 32'h46);
      strobe(0, 8'h3C, 4);
      chk(accepted_trace_id, 32'h5A, "trace four");
      strobe(0, 8'h3C, 1);
      chk(accepted_trace_id, 32'h3C, "trace five");
      apb(1'b1, 12'h050, 32'h10);
      for (int a = 0; a < 2; a++) begin
         apb(1'b1, 12'h038, a ? 32'h86 : 32'h06);
         for (int i = 1; i < 5; i++) strobe(0, 8'h11 * i, 1);
         chk(trace_unstable_state, 32'h1, "unstable");
         strobe(0, 8'h44, 2);
         chk(trace_unstable_state, 32'h0, "stable");
      end
      strobe(0, 8'h11, 1);
      strobe(0, 8'h22, 1);
      apb(1'b1, 12'h044, 32'h01);
      apb(1'b1, 12'h040, 32'h01);
      strobe(0, 8'h33, 1);
      chk(receive_alarm_port, 32'h1, "unstable rdi");
      chk(ais_insert, 32'h1, "unstable ais");
      $display("test trace done");
      apb(1'b1, 12'h038, 32'h06);
      strobe(2, 8'h05, 4);
      chk(remote_defect_code, 32'h0, "rdi code early");
      strobe(2, 8'h05, 1);
      chk(remote_defect_code, 32'h5, "rdi code five");
      apb(1'b1, 12'h038, 32'h0E);
      strobe(2, 8'h03, 9);
      chk(remote_defect_code, 32'h5, "rdi code nine");
      strobe(2, 8'h03, 1);
      chk(remote_defect_code, 32'h3, "rdi code ten");
      strobe(1, 8'h06, 1);
      chk(pdi_detect, 32'h1, "defect code");
      strobe(1, 8'h05, 1);
      chk(pdi_detect, 32'h0, "other label");
      apb(1'b1, 12'h050, 32'h81);
      strobe(1, 8'hFE, 1);
      chk(pdi_detect, 32'h1, "tu3 extended");
      strobe(1, 8'h06, 1);
      chk(pdi_detect, 32'h0, "tu3 short");
      $display("test filters done");
      end_of_test();
   end
endmodule // test_tributary_alarm_action_control

//--- tb/trib_stream_source.sv
`timescale 1ns/1ps
// Far-side stream source: a counting byte stream with a multiframe
// boundary once every eight bytes, as the incoming framer delivers it.
module trib_stream_source (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Tributary stream towards the block.
   output logic multiframe_boundary,
   output logic data_in_valid,
   output logic [7:0] data_in
);
   logic [7:0] count;

   // The top data bit is always low, so an all-ones byte at the far
   // output can only come from inserted AIS, never from live traffic.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         count <= 8'h00;
         data_in_valid <= 1'b0;
         data_in <= 8'h00;
         multiframe_boundary <= 1'b0;
      end else begin
         count <= count + 8'h01;
         data_in_valid <= 1'b1;
         data_in <= {1'b0, count[6:0]};
         multiframe_boundary <= (count[2:0] == 3'h7);
      end
   end
endmodule // trib_stream_source
